// ### dscr_pkg.sv
// Purpose: shared constants and carriers for the dsp status/context bank
// Assumes: 16-bit core data path, one core clock
// Notes: register select codes are local numbering, not bus addresses
`default_nettype none
package dscr_pkg;
  localparam int DW = 16;
  localparam int NPTR = 6;
  localparam int ACCW = 36;
  localparam int BC_MAX = 3'h4;
  // register select codes for the core move path
  localparam logic [1:0] SEL_ST0 = 2'h0;
  localparam logic [1:0] SEL_ST1 = 2'h1;
  localparam logic [1:0] SEL_ST2 = 2'h2;
  localparam logic [1:0] SEL_ICR = 2'h3;
  // field positions
  localparam int ST1_PS_LO = 10;
  localparam int ST2_IP1 = 15;
  localparam int ST2_IP0 = 14;
  localparam int ST2_IP2 = 13;
  localparam int ST2_IU1 = 11;
  localparam int ST2_IU0 = 10;
  localparam int ST2_OU1 = 9;
  localparam int ST2_OU0 = 8;
  localparam int ST2_S = 7;
  localparam int ST2_IM2 = 6;
  localparam int ICR_LP = 4;
  localparam int ICR_BC_LO = 5;
  // reset values
  localparam logic [1:0] PS_RST = 2'h0;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [15:0] ST0_RST = 16'h0000;
  localparam logic [15:0] DVM_RST = 16'h0000;
  // writable masks of first status register (flags, masks, sat)
  localparam logic [15:0] ST0_WMASK = 16'h0FFF;
  // shadow set of the first status register: bits 11:2 and 0
  localparam logic [15:0] ST0_SHMASK = 16'h0FFD;

  // register write request from the core
  typedef struct packed {
    logic we;
    logic [1:0] sel;
    logic [DW-1:0] data;
  } dscr_wr_t;

  // context event strobes from the sequencer
  typedef struct packed {
    logic int_nmi;
    logic [2:0] int_mask;
    logic interrupt_return_instr;
    logic context_switch_instr;
    logic trap;
  } dscr_evt_t;
endpackage
`default_nettype wire

// ### dscr_regs.sv
// Purpose: status, configuration, context switch and value match registers
// Assumes: sequencer issues one-cycle strobes; pins are asynchronous
// Notes: accumulators live outside; this block issues the swap strobe
//
// How it works
// [RULE_01] product scale 00 none, 01 right one, 10 left one, 11 left two
// [RULE_02] product scale clears on reset, writable via second status reg
// [RULE_03] data page loaded by page-load instruction or status write
// [RULE_04] pending bits follow live interrupt levels regardless of masks
// [RULE_05] user input bits show the synchronised input pin levels
// [RULE_06] user output bits drive output pins, clear on reset
// [RULE_07] shift bit zero arithmetic, one logical; resets zero, writable
// [RULE_08] third interrupt mask enables third interrupt; resets zero
// [RULE_09] six modulo enables select modulo pointer updates; reset zero
// [RULE_10] pointer-modify option bypasses that pointer's modulo enable
// [RULE_11] enabled interrupts switch context on acceptance, no latency
// [RULE_12] entry pushes shadow of status bits, return pops them
// [RULE_13] entry and return swap data page with alternate page
// [RULE_14] entry and return swap second primary and alternate accumulators
// [RULE_15] explicit instruction performs the same exchange on demand
// [RULE_16] nesting counter 0 outside loops, 1 to 4 by level
// [RULE_17] nesting counter read-only, clears on reset and loop clear
// [RULE_18] writing one to in-loop clears loop and counter; zero no effect
// [RULE_19] four context enables clear on reset and are writable
// [RULE_20] match flag when match register equals main data bus
// [RULE_21] trap service copies program counter into match register
// [RULE_22] match register moves to and from accumulators
// [RULE_23] reserved and unused bits read zero and ignore writes
// [RULE_24] counter increments on entry, decrements on end, saturating
// [RULE_25] return with switching enabled restores all in same cycle; acc_swap is registered, so the accumulators swap one cycle later
`timescale 1ns/1ps
`default_nettype none
module dscr_regs
  import dscr_pkg::*;
#(
  parameter int NUM_PTR = NPTR
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core register access
  input wire dscr_wr_t reg_wr,
  input wire logic [1:0] reg_rd_sel,
  output logic [DW-1:0] reg_rd_data,
  // first status register flags computed by the alu
  input wire logic st0_upd,
  input wire logic [DW-1:0] st0_flags,
  // page load instruction
  input wire logic page_load_instr,
  input wire logic [7:0] page_load_val,
  // interrupt pins and user pins
  input wire logic maskable_irq_zero,
  input wire logic maskable_irq_one,
  input wire logic maskable_irq_two,
  input wire logic user_input_pin_zero,
  input wire logic user_input_pin_one,
  output logic user_output_pin_zero,
  output logic user_output_pin_one,
  // context events
  input wire dscr_evt_t evt,
  output logic acc_swap,
  // block repeat
  input wire logic loop_enter,
  input wire logic loop_done,
  // pointer modify
  input wire logic pointer_modify_instr,
  input wire logic pointer_modify_nomod,
  input wire logic [2:0] pointer_sel,
  output logic ptr_use_modulo,
  // status to the datapath
  output logic [1:0] product_scale,
  output logic shift_logical,
  output logic [7:0] data_page,
  output logic [3:0] ctx_enable,
  // value match
  input wire logic [DW-1:0] main_data_bus,
  input wire logic [DW-1:0] prog_counter,
  input wire logic dvm_wr,
  input wire logic [DW-1:0] dvm_wdata,
  output logic [DW-1:0] value_match_register,
  output logic value_match
);

  // the third status register holds at most six modulo enables
  if (NUM_PTR < 1 || NUM_PTR > NPTR) begin : g_bad_num_ptr
    $error("NUM_PTR out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [DW-1:0] st0_ff;
  logic [1:0] ps_ff;
  logic [7:0] page_ff;
  logic [7:0] alt_page_ff;
  logic [1:0] uout_ff;
  logic shift_ff;
  logic im2_ff;
  logic [NUM_PTR-1:0] modulo_enable_ff;
  logic [NUM_PTR-1:0] nxt_modulo;
  logic in_loop_ff;
  logic [2:0] bc_ff;
  logic [3:0] ctxen_ff;
  logic [DW-1:0] sh_st0_ff;
  logic [1:0] sh_ps_ff;
  logic [7:0] sh_st2_ff;
  logic [DW-1:0] dvm_ff;
  logic [2:0] irq_s1_ff;
  logic [2:0] irq_s2_ff;
  logic [1:0] uin_s1_ff;
  logic [1:0] uin_s2_ff;
  logic acc_swap_ff;
  logic match_ff;
  logic [DW-1:0] rd_ff;
  logic ptr_mod_ff;

  logic ctx_entry;
  logic ctx_exit;
  logic ctx_any;
  logic wr_st0;
  logic wr_st1;
  logic wr_st2;
  logic wr_icr;
  logic [DW-1:0] st1_view;
  logic [DW-1:0] st2_view;
  logic [DW-1:0] icr_view;

  assign wr_st0 = reg_wr.we && reg_wr.sel == SEL_ST0;
  assign wr_st1 = reg_wr.we && reg_wr.sel == SEL_ST1;
  assign wr_st2 = reg_wr.we && reg_wr.sel == SEL_ST2;
  assign wr_icr = reg_wr.we && reg_wr.sel == SEL_ICR;

  // entry on accepted interrupt with its enable set, or explicit instr
  assign ctx_entry = (evt.int_nmi && ctxen_ff[0]) ||
                     (evt.int_mask[0] && ctxen_ff[1]) ||
                     (evt.int_mask[1] && ctxen_ff[2]) ||
                     (evt.int_mask[2] && ctxen_ff[3]) ||
                     evt.context_switch_instr; // [RULE_11] [RULE_15]
  // sequencer flags interrupt_return_instr only for a switching interrupt
  assign ctx_exit = evt.interrupt_return_instr; // [RULE_25]
  assign ctx_any = ctx_entry || ctx_exit;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; second stage alone feeds logic
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_s1_ff <= 3'h0;
      irq_s2_ff <= 3'h0;
      uin_s1_ff <= 2'h0;
      uin_s2_ff <= 2'h0;
    end else begin
      irq_s1_ff <= {maskable_irq_two, maskable_irq_one, maskable_irq_zero};
      irq_s2_ff <= irq_s1_ff;
      uin_s1_ff <= {user_input_pin_one, user_input_pin_zero};
      uin_s2_ff <= uin_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first status register: shadow push and pop of flags
  always_ff @(posedge clk) begin
    if (rst) begin
      st0_ff <= ST0_RST;
      sh_st0_ff <= ST0_RST;
    end else begin
      if (ctx_entry) begin
        sh_st0_ff <= st0_ff & ST0_SHMASK; // [RULE_12]
      end
      if (ctx_exit) begin
        // bit 1 (global enable) is left to the sequencer
        st0_ff <= (sh_st0_ff & ST0_SHMASK) |
                  (st0_ff & ~ST0_SHMASK & ST0_WMASK); // [RULE_12]
      end else if (wr_st0) begin
        st0_ff <= reg_wr.data & ST0_WMASK; // [RULE_23]
      end else if (st0_upd) begin
        st0_ff <= st0_flags & ST0_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second status register: scale and page
  always_ff @(posedge clk) begin
    if (rst) begin
      ps_ff <= PS_RST;
      sh_ps_ff <= PS_RST;
    end else begin
      if (ctx_entry) begin
        sh_ps_ff <= ps_ff; // [RULE_12]
      end
      if (ctx_exit) begin
        ps_ff <= sh_ps_ff;
      end else if (wr_st1) begin
        ps_ff <= reg_wr.data[ST1_PS_LO +: 2]; // [RULE_02]
      end
    end
  end

  // page swaps with the alternate copy on entry and return
  always_ff @(posedge clk) begin
    if (rst) begin
      page_ff <= PAGE_RST;
      alt_page_ff <= PAGE_RST;
    end else if (ctx_any) begin
      page_ff <= alt_page_ff; // [RULE_13]
      alt_page_ff <= page_ff;
    end else if (page_load_instr) begin
      page_ff <= page_load_val; // [RULE_03]
    end else if (wr_st1) begin
      page_ff <= reg_wr.data[7:0]; // [RULE_03]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // third status register: outputs, shift, mask, modulo enables
  assign nxt_modulo = reg_wr.data[NUM_PTR-1:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      uout_ff <= 2'h0; // [RULE_06]
      shift_ff <= 1'b0;
      im2_ff <= 1'b0;
      modulo_enable_ff <= '0;
      sh_st2_ff <= 8'h00;
    end else begin
      if (ctx_entry) begin
        sh_st2_ff <= st2_view[7:0]; // [RULE_12]
      end
      if (ctx_exit) begin
        shift_ff <= sh_st2_ff[ST2_S];
        im2_ff <= sh_st2_ff[ST2_IM2];
        modulo_enable_ff <= sh_st2_ff[NUM_PTR-1:0];
      end else if (wr_st2) begin
        shift_ff <= reg_wr.data[ST2_S]; // [RULE_07]
        im2_ff <= reg_wr.data[ST2_IM2]; // [RULE_08]
        modulo_enable_ff <= nxt_modulo; // [RULE_09]
      end
      if (wr_st2) begin
        uout_ff <= {reg_wr.data[ST2_OU1], reg_wr.data[ST2_OU0]}; // [RULE_06]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal configuration: loop state and context enables
  always_ff @(posedge clk) begin
    if (rst) begin
      in_loop_ff <= 1'b0;
      bc_ff <= 3'h0;
    end else if (wr_icr && reg_wr.data[ICR_LP]) begin
      in_loop_ff <= 1'b0; // [RULE_18]
      bc_ff <= 3'h0; // [RULE_17]
    end else if (loop_enter && bc_ff < 3'(BC_MAX)) begin
      bc_ff <= bc_ff + 3'h1; // [RULE_24]
      in_loop_ff <= 1'b1; // [RULE_16]
    end else if (loop_done && bc_ff != 3'h0) begin
      bc_ff <= bc_ff - 3'h1; // [RULE_24]
      in_loop_ff <= (bc_ff != 3'h1);
    end
  end

  // context enables: bit 0 nonmaskable, bits 3:1 maskable two..zero order
  always_ff @(posedge clk) begin
    if (rst) begin
      ctxen_ff <= 4'h0; // [RULE_19]
    end else if (wr_icr) begin
      ctxen_ff <= reg_wr.data[3:0]; // [RULE_19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // value match register and comparator
  always_ff @(posedge clk) begin
    if (rst) begin
      dvm_ff <= DVM_RST;
    end else if (evt.trap) begin
      dvm_ff <= prog_counter; // [RULE_21]
    end else if (dvm_wr) begin
      dvm_ff <= dvm_wdata; // [RULE_22]
    end
  end

  // registered compare keeps the emulation path off the bus timing
  always_ff @(posedge clk) begin
    if (rst) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= (dvm_ff == main_data_bus); // [RULE_20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read views; unused bits tie to zero
  assign st1_view = {4'h0, ps_ff, 2'h0, page_ff}; // [RULE_23]
  always_comb begin
    st2_view = '0;
    st2_view[ST2_IP1] = irq_s2_ff[1]; // [RULE_04]
    st2_view[ST2_IP0] = irq_s2_ff[0];
    st2_view[ST2_IP2] = irq_s2_ff[2];
    st2_view[ST2_IU1] = uin_s2_ff[1]; // [RULE_05]
    st2_view[ST2_IU0] = uin_s2_ff[0];
    st2_view[ST2_OU1] = uout_ff[1];
    st2_view[ST2_OU0] = uout_ff[0];
    st2_view[ST2_S] = shift_ff;
    st2_view[ST2_IM2] = im2_ff;
    st2_view[NUM_PTR-1:0] = modulo_enable_ff;
  end
  assign icr_view = {8'h00, bc_ff, in_loop_ff, ctxen_ff}; // [RULE_23]

  // registered read mux and datapath strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ff <= '0;
      acc_swap_ff <= 1'b0;
      ptr_mod_ff <= 1'b0;
    end else begin
      case (reg_rd_sel)
        SEL_ST0: rd_ff <= st0_ff;
        SEL_ST1: rd_ff <= st1_view;
        SEL_ST2: rd_ff <= st2_view;
        default: rd_ff <= icr_view;
      endcase
      acc_swap_ff <= ctx_any; // [RULE_14]
      ptr_mod_ff <= (pointer_sel < 3'(NUM_PTR)) &&
                    modulo_enable_ff[pointer_sel] &&
                    !(pointer_modify_instr &&
                      pointer_modify_nomod); // [RULE_10]
    end
  end

  // scale field drives the product shifter select
  assign product_scale = ps_ff; // [RULE_01]
  assign shift_logical = shift_ff;
  assign data_page = page_ff;
  assign ctx_enable = ctxen_ff;
  assign user_output_pin_zero = uout_ff[0];
  assign user_output_pin_one = uout_ff[1];
  assign value_match_register = dvm_ff;
  assign value_match = match_ff;
  assign reg_rd_data = rd_ff;
  assign acc_swap = acc_swap_ff;
  assign ptr_use_modulo = ptr_mod_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_page_swap: assert property ( // [RULE_13]
    @(posedge clk) disable iff (rst)
    ctx_any |=> data_page == $past(alt_page_ff))
    else $error("page swap wrong");
  a_acc_swap_pulse: assert property ( // [RULE_14]
    @(posedge clk) disable iff (rst)
    ctx_any |=> acc_swap)
    else $error("accumulator swap missing");
  a_loop_break: assert property ( // [RULE_18]
    @(posedge clk) disable iff (rst)
    wr_icr && reg_wr.data[ICR_LP] |=> bc_ff == 3'h0 && !in_loop_ff)
    else $error("loop break failed");
  a_bc_range: assert property ( // [RULE_16]
    @(posedge clk) disable iff (rst)
    bc_ff <= 3'(BC_MAX) && (in_loop_ff == (bc_ff != 3'h0)))
    else $error("nesting count out of range");
  a_trap_copy: assert property ( // [RULE_21]
    @(posedge clk) disable iff (rst)
    evt.trap |=> value_match_register == $past(prog_counter))
    else $error("trap pc copy missing");
  a_match_flag: assert property ( // [RULE_20]
    @(posedge clk) disable iff (rst)
    value_match == $past(dvm_ff == main_data_bus))
    else $error("value match wrong");
  // every return pops, so the check is reached by any return sequence
  a_shadow_pop: assert property ( // [RULE_12]
    @(posedge clk) disable iff (rst)
    ctx_exit |=> product_scale == $past(sh_ps_ff) &&
    shift_logical == $past(sh_st2_ff[ST2_S]))
    else $error("shadow pop wrong");
  a_icr_reserved: assert property ( // [RULE_23]
    @(posedge clk) disable iff (rst)
    reg_rd_sel == SEL_ICR |=> reg_rd_data[15:8] == 8'h00)
    else $error("reserved bits not zero");
  a_ctx_enable_wr: assert property ( // [RULE_19]
    @(posedge clk) disable iff (rst)
    wr_icr |=> ctx_enable == $past(reg_wr.data[3:0]))
    else $error("context enable write lost");
  a_uout_wr: assert property ( // [RULE_06]
    @(posedge clk) disable iff (rst)
    wr_st2 |=> user_output_pin_one == $past(reg_wr.data[ST2_OU1]))
    else $error("user output write lost");

endmodule
`default_nettype wire

// ### dscr_core_model.sv
// Purpose: core-side partner holding the swapped accumulator pair
// Assumes: acc_swap is a one-cycle pulse from the bank
// Notes: also counts value-match cycles the way an emulator would
`timescale 1ns/1ps
`default_nettype none
module dscr_core_model
  import dscr_pkg::*;
#(
  parameter logic [ACCW-1:0] A1_INIT = 36'h000001111,
  parameter logic [ACCW-1:0] B1_INIT = 36'h000002222
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bank side
  input wire logic acc_swap,
  input wire logic value_match,
  output logic [DW-1:0] dvm_wdata,
  output logic [ACCW-1:0] acc_pri,
  output logic [7:0] hit_cnt
);
  logic [ACCW-1:0] acc_pri_ff;
  logic [ACCW-1:0] acc_alt_ff;
  logic [7:0] hit_ff;
  //////////////////////////////////////////////////////////////////////////
  // swap on every strobe; a stray double strobe shows as a mismatch
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_pri_ff <= A1_INIT;
      acc_alt_ff <= B1_INIT;
    end else if (acc_swap) begin
      acc_pri_ff <= acc_alt_ff;
      acc_alt_ff <= acc_pri_ff;
    end
  end
  // emulator side counts cycles with the match flag up
  always_ff @(posedge clk) begin
    if (rst) begin
      hit_ff <= 8'h00;
    end else if (value_match) begin
      hit_ff <= hit_ff + 8'h01;
    end
  end
  // match register loads from the low word of the accumulator
  assign dvm_wdata = acc_pri_ff[DW-1:0];
  assign acc_pri = acc_pri_ff;
  assign hit_cnt = hit_ff;
endmodule
`default_nettype wire

// ### tb_dscr_regs.sv
// Purpose: self-checking bench for the status and context register bank
// Assumes: inputs move 1 ns after the rising edge
// Notes: one write or event per two cycles, pins settle over 2 edges
`timescale 1ns/1ps
`default_nettype none
module tb_dscr_regs;
  import dscr_pkg::*;
  localparam logic [ACCW-1:0] A1V = 36'h000001111;
  localparam logic [ACCW-1:0] B1V = 36'h000002222;
  logic clk, rst, st0_upd, pl, irq0, irq1, irq2, uin0, uin1, uout0, uout1;
  logic acc_swap, le, ld, pm, pmn, pum, sl, dvm_wr, vm;
  logic [1:0] rd_sel, ps;
  logic [2:0] psel;
  logic [3:0] ce;
  logic [7:0] pl_val, dp, hits;
  logic [DW-1:0] rd_data, st0_flags, mdb, pc, dvm_wdata, vmr;
  logic [ACCW-1:0] acc_pri;
  dscr_wr_t reg_wr;
  dscr_evt_t evt;
  int err_count = 0;
  int comparisons = 0;
  //////////////////////////////////////////////////////////////////////////
  dscr_regs uut (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd_sel(rd_sel),
    .reg_rd_data(rd_data), .st0_upd(st0_upd), .st0_flags(st0_flags),
    .page_load_instr(pl), .page_load_val(pl_val),
    .maskable_irq_zero(irq0), .maskable_irq_one(irq1),
    .maskable_irq_two(irq2), .user_input_pin_zero(uin0),
    .user_input_pin_one(uin1), .user_output_pin_zero(uout0),
    .user_output_pin_one(uout1), .evt(evt), .acc_swap(acc_swap),
    .loop_enter(le), .loop_done(ld), .pointer_modify_instr(pm),
    .pointer_modify_nomod(pmn), .pointer_sel(psel),
    .ptr_use_modulo(pum), .product_scale(ps), .shift_logical(sl),
    .data_page(dp), .ctx_enable(ce), .main_data_bus(mdb),
    .prog_counter(pc), .dvm_wr(dvm_wr), .dvm_wdata(dvm_wdata),
    .value_match_register(vmr), .value_match(vm)
  );
  dscr_core_model #(.A1_INIT(A1V), .B1_INIT(B1V)) core (
    .clk(clk), .rst(rst), .acc_swap(acc_swap), .value_match(vm),
    .dvm_wdata(dvm_wdata), .acc_pri(acc_pri), .hit_cnt(hits)
  );
  //////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] s, input logic [DW-1:0] d);
    reg_wr = {1'b1, s, d};
    tick();
    reg_wr.we = 1'b0;
    tick();
  endtask
  // read data is registered, so it is valid one edge after select
  task automatic rd(input logic [1:0] s, input logic [DW-1:0] e);
    rd_sel = s;
    tick();
    chk(rd_data, e);
  endtask
  // swap strobe must stand in the cycle right after the event
  task automatic ev(input dscr_evt_t v, input logic sw);
    evt = v;
    tick();
    chk(DW'(acc_swap), DW'(sw));
    evt = '0;
    tick();
  endtask
  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, far beyond the roughly 130 cycles the run needs
  initial begin
    #200000;
    err_count++;
    final_report();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    reg_wr = '0;
    evt = '0;
    rd_sel = '0;
    {st0_upd, pl, le, ld, pm, pmn, dvm_wr} = '0;
    {irq0, irq1, irq2, uin0, uin1} = '0;
    {st0_flags, pc} = '0;
    pl_val = '0;
    psel = '0;
    mdb = 16'hFFFF;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(i[1:0], 16'h0000);
    end
    chk({14'h0, uout1, uout0}, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wr(SEL_ST1, {4'hF, i[1:0], 2'h3, 8'h5A});
      chk(DW'(ps), DW'(i[1:0]));
      rd(SEL_ST1, {4'h0, i[1:0], 10'h05A});
    end
    chk(DW'(dp), 16'h005A);
    $display("scale test done");
    {irq0, irq1, irq2, uin0, uin1} = 5'b10110;
    wr(SEL_ST2, 16'hFFFF);
    tick();
    rd(SEL_ST2, 16'h67FF);
    chk({14'h0, uout1, uout0}, 16'h0003);
    chk(DW'(sl), 16'h0001);
    {irq0, irq1, irq2, uin0, uin1} = 5'b01001;
    repeat (2) tick();
    rd(SEL_ST2, 16'h8BFF);
    {irq0, irq1, irq2, uin0, uin1} = '0;
    wr(SEL_ST2, 16'h0015);
    chk({13'h0, sl, uout1, uout0}, 16'h0000);
    for (int p = 0; p < 6; p++) begin
      for (int n = 0; n < 2; n++) begin
        pm = 1'b1;
        pmn = n[0];
        psel = p[2:0];
        tick();
        chk(DW'(pum), DW'(p[0] == 1'b0 && n == 0));
        pm = 1'b0;
        tick();
      end
    end
    $display("pin and modulo test done");
    wr(SEL_ICR, 16'hFFE5);
    rd(SEL_ICR, 16'h0005);
    chk(DW'(ce), 16'h0005);
    for (int k = 0; k < 5; k++) begin
      le = 1'b1;
      tick();
      le = 1'b0;
      tick();
    end
    rd(SEL_ICR, 16'h0095);
    ld = 1'b1;
    tick();
    ld = 1'b0;
    tick();
    rd(SEL_ICR, 16'h0075);
    wr(SEL_ICR, 16'h0005);
    rd(SEL_ICR, 16'h0075);
    wr(SEL_ICR, 16'h0013);
    rd(SEL_ICR, 16'h0003);
    $display("loop test done");
    wr(SEL_ST0, 16'h0FFF);
    wr(SEL_ST1, 16'h085A);
    wr(SEL_ST2, 16'h00A5);
    ev(7'h08, 1'b1);
    chk(DW'(dp), 16'h0000);
    chk(acc_pri[15:0], B1V[15:0]);
    rd(SEL_ST0, 16'h0FFF);
    st0_flags = 16'hF000;
    st0_upd = 1'b1;
    tick();
    st0_upd = 1'b0;
    pl_val = 8'h33;
    pl = 1'b1;
    tick();
    pl = 1'b0;
    tick();
    chk(DW'(dp), 16'h0033);
    wr(SEL_ST1, 16'h0433);
    wr(SEL_ST2, 16'h0300);
    rd(SEL_ST0, 16'h0000);
    ev(7'h04, 1'b1);
    rd(SEL_ST0, 16'h0FFD);
    rd(SEL_ST1, 16'h085A);
    rd(SEL_ST2, 16'h03A5);
    chk(acc_pri[15:0], A1V[15:0]);
    ev(7'h10, 1'b0);
    chk(DW'(dp), 16'h005A);
    ev(7'h02, 1'b1);
    chk(DW'(dp), 16'h0033);
    ev(7'h40, 1'b1);
    chk(DW'(dp), 16'h005A);
    ev(7'h04, 1'b1);
    chk(DW'(dp), 16'h0033);
    chk(acc_pri[15:0], B1V[15:0]);
    $display("context test done");
    pc = 16'hBEEF;
    evt = 7'h01;
    dvm_wr = 1'b1;
    tick();
    evt = '0;
    dvm_wr = 1'b0;
    tick();
    chk(vmr, 16'hBEEF);
    dvm_wr = 1'b1;
    tick();
    dvm_wr = 1'b0;
    tick();
    chk(vmr, B1V[15:0]);
    mdb = 16'h2222;
    repeat (2) tick();
    chk(DW'(vm), 16'h0001);
    mdb = 16'h2223;
    repeat (2) tick();
    chk(DW'(vm), 16'h0000);
    chk(DW'(hits), 16'h0002);
    $display("value match test done");
    final_report();
  end
endmodule
`default_nettype wire
